// *** design/pcg_pkg.sv ***
// Constants for the peripheral clock gating controller: register map, field layout,
// reset values and mode encodings.
// Assumes a single 32-bit AHB-Lite slave port with word-aligned registers.
package pcg_pkg;

   // Register byte offsets
   localparam logic [11:0] PCG_OFS_RUN_GATE    = 12'h108;
   localparam logic [11:0] PCG_OFS_SLEEP_GATE  = 12'h118;
   localparam logic [11:0] PCG_OFS_DEEP_GATE   = 12'h128;
   localparam logic [11:0] PCG_OFS_DEEP_CLKSEL = 12'h144;
   localparam logic [11:0] PCG_OFS_FAULT_CLR   = 12'h150;
   localparam logic [11:0] PCG_OFS_LDO_RST_EN  = 12'h160;
   localparam logic [11:0] PCG_OFS_INT_STATUS  = 12'h170;
   localparam logic [11:0] PCG_OFS_INT_MASK    = 12'h174;
   localparam logic [11:0] PCG_OFS_STATE       = 12'h178;

   // Field positions
   localparam int PCG_NUM_PORTS    = 5;
   localparam int PCG_BIT_OSC_OVR   = 0;
   localparam int PCG_BIT_FAULT_CLR = 0;
   localparam int PCG_BIT_LDO_EN   = 0;

   // Interrupt status bits
   localparam int PCG_IRQ_CLK_FAULT = 0;
   localparam int PCG_IRQ_BUS_FAULT = 1;
   localparam int PCG_IRQ_LDO       = 2;
   localparam int PCG_IRQ_WAKE      = 3;
   localparam int PCG_NUM_IRQ       = 4;

   // State register field positions
   localparam int PCG_ST_MODE_LSB  = 0;
   localparam int PCG_ST_FAULT     = 3;
   localparam int PCG_ST_SRC_LSB   = 4;
   localparam int PCG_ST_EN_LSB    = 8;

   // Reset values
   localparam logic [PCG_NUM_PORTS-1:0] PCG_GATE_RST = 5'h00;
   localparam logic                     PCG_BIT_RST  = 1'b0;
   localparam logic [PCG_NUM_IRQ-1:0]   PCG_IRQ_RST  = 4'h0;

   // System clock source codes
   localparam logic [1:0] PCG_SRC_MAIN     = 2'h0;
   localparam logic [1:0] PCG_SRC_INTERNAL = 2'h1;

   // AHB encodings
   localparam logic [1:0] PCG_HTRANS_NONSEQ = 2'h2;
   localparam logic       PCG_HRESP_OKAY    = 1'b0;

   typedef enum logic [2:0] {
      PCG_MODE_RUN   = 3'b001,
      PCG_MODE_SLEEP = 3'b010,
      PCG_MODE_DEEP  = 3'b100
   } pcg_mode_e;

endpackage

// *** design/pcg_top.sv ***
// Peripheral clock gating controller: per-power-mode gating of five I/O port units,
// deep-sleep oscillator override, clock fault clear, regulator reset enable.
// Assumes power-mode events, fault detector and port access strobes come from logic on
// hclk; the regulator indication is asynchronous and is synchronised here.
//
// Summary of operation
// - Each gating bit enables one unit's clock; clear means unit unclocked and disabled.
// - Access to a unit whose clock is gated off answers with a bus fault.
// - All gating bits reset to zero, so every unit starts unclocked.
// - Run, sleep, deep-sleep gating registers; copy for current mode governs.
// - Sleep and deep-sleep copies apply only with auto clock gating set.
// - Bits 0 to 4 enable ports A to E; bits 31:5 reserved.
// - Reserved bits read any value; software preserves them on writes.
// - Override set at deep-sleep entry: internal oscillator on, selected, main off.
// - Deep-sleep exit restores the clock source in use at entry.
// - Override clear keeps main oscillator during deep-sleep; bit 0 resets to 0.
// - While a verification fault is active, a known good clock is substituted.
// - The clear bit holds the written value; hardware never clears it.
// - Regulator reset enable set lets an unregulated indication reset the part.
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
module pcg_top
   import pcg_pkg::*;
#(
   parameter int NUM_PORTS = PCG_NUM_PORTS
) (
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic      [31:0]          hrdata,
   output logic                      hreadyout,
   output logic                      hresp,
   input  wire logic                 auto_clock_gating,
   input  wire logic                 sleep_enter,
   input  wire logic                 sleep_deep,
   input  wire logic                 wake_event,
   input  wire logic [1:0]           run_clk_src,
   input  wire logic                 clk_fault_detect,
   input  wire logic                 ldo_unregulated,
   input  wire logic [NUM_PORTS-1:0] port_access,
   output logic      [NUM_PORTS-1:0] port_clk_en,
   output logic      [NUM_PORTS-1:0] port_gclk,
   output logic                      port_bus_fault,
   output logic      [1:0]           sys_clk_src,
   output logic                      int_osc_power_up,
   output logic                      main_osc_power_down,
   output logic                      clk_fault_active,
   output logic                      part_reset_req,
   output logic                      irq
);

   logic [NUM_PORTS-1:0]   run_port_clock_gate;
   logic [NUM_PORTS-1:0]   sleep_port_clock_gate;
   logic [NUM_PORTS-1:0]   deepsleep_port_clock_gate;
   logic                   internal_osc_override;
   logic                   verify_fault_clear_bit;
   logic                   regulator_reset_enable;
   logic [PCG_NUM_IRQ-1:0] int_status;
   logic [PCG_NUM_IRQ-1:0] int_mask;

   logic                   wr_pend;
   logic                   rd_pend;
   logic [11:0]            dp_addr;
   logic                   addr_ok;
   logic                   wr_strobe;
   logic                   rd_strobe;
   logic [31:0]            next_hrdata;

   pcg_mode_e              mode;
   pcg_mode_e              next_mode;
   logic [1:0]             saved_src;
   logic                   deep_override;
   logic [NUM_PORTS-1:0]   next_clk_en;
   logic [NUM_PORTS-1:0]   en_latch;
   logic                   clr_prev;
   logic                   ldo_sync1;
   logic                   ldo_sync2;
   logic                   ldo_prev;
   logic [PCG_NUM_IRQ-1:0] irq_events;

   function automatic logic is_reg(input logic [11:0] a, input logic [11:0] ofs);
      return a == ofs;
   endfunction

   // Bus interface: writes finish with no wait state, reads take one wait state so
   // read data always reflects a write made in the cycle before.
   assign addr_ok   = hsel && hready && (htrans == PCG_HTRANS_NONSEQ);
   assign wr_strobe = wr_pend;
   assign rd_strobe = rd_pend && !hreadyout;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         dp_addr <= 12'h000;
      end else if (hready) begin
         wr_pend <= addr_ok && hwrite;
         rd_pend <= addr_ok && !hwrite;
         if (addr_ok) begin
            dp_addr <= {haddr[11:2], 2'b00};
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
      end else if (addr_ok && !hwrite) begin
         hreadyout <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
      end
   end

   assign hresp = PCG_HRESP_OKAY;

   // Reserved bits read as zero; only implemented bits are stored.
   always_comb begin
      next_hrdata = 32'h0000_0000;
      if (is_reg(dp_addr, PCG_OFS_RUN_GATE)) begin
         next_hrdata[NUM_PORTS-1:0] = run_port_clock_gate;
      end else if (is_reg(dp_addr, PCG_OFS_SLEEP_GATE)) begin
         next_hrdata[NUM_PORTS-1:0] = sleep_port_clock_gate;
      end else if (is_reg(dp_addr, PCG_OFS_DEEP_GATE)) begin
         next_hrdata[NUM_PORTS-1:0] = deepsleep_port_clock_gate;
      end else if (is_reg(dp_addr, PCG_OFS_DEEP_CLKSEL)) begin
         next_hrdata[PCG_BIT_OSC_OVR] = internal_osc_override;
      end else if (is_reg(dp_addr, PCG_OFS_FAULT_CLR)) begin
         next_hrdata[PCG_BIT_FAULT_CLR] = verify_fault_clear_bit;
      end else if (is_reg(dp_addr, PCG_OFS_LDO_RST_EN)) begin
         next_hrdata[PCG_BIT_LDO_EN] = regulator_reset_enable;
      end else if (is_reg(dp_addr, PCG_OFS_INT_STATUS)) begin
         next_hrdata[PCG_NUM_IRQ-1:0] = int_status;
      end else if (is_reg(dp_addr, PCG_OFS_INT_MASK)) begin
         next_hrdata[PCG_NUM_IRQ-1:0] = int_mask;
      end else if (is_reg(dp_addr, PCG_OFS_STATE)) begin
         next_hrdata[PCG_ST_MODE_LSB +: 3]       = mode;
         next_hrdata[PCG_ST_FAULT]               = clk_fault_active;
         next_hrdata[PCG_ST_SRC_LSB +: 2]        = sys_clk_src;
         next_hrdata[PCG_ST_EN_LSB +: NUM_PORTS] = port_clk_en;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_strobe) begin
         hrdata <= next_hrdata;
      end
   end

   // Gating registers, bits 0..4 for ports A..E, all clear after reset.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_port_clock_gate       <= PCG_GATE_RST;
         sleep_port_clock_gate     <= PCG_GATE_RST;
         deepsleep_port_clock_gate <= PCG_GATE_RST;
      end else if (wr_strobe) begin
         if (is_reg(dp_addr, PCG_OFS_RUN_GATE)) begin
            run_port_clock_gate <= hwdata[NUM_PORTS-1:0];
         end
         if (is_reg(dp_addr, PCG_OFS_SLEEP_GATE)) begin
            sleep_port_clock_gate <= hwdata[NUM_PORTS-1:0];
         end
         if (is_reg(dp_addr, PCG_OFS_DEEP_GATE)) begin
            deepsleep_port_clock_gate <= hwdata[NUM_PORTS-1:0];
         end
      end
   end

   // Single-bit control registers; the clear bit is only ever changed by software.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         internal_osc_override  <= PCG_BIT_RST;
         verify_fault_clear_bit <= PCG_BIT_RST;
         regulator_reset_enable <= PCG_BIT_RST;
      end else if (wr_strobe) begin
         if (is_reg(dp_addr, PCG_OFS_DEEP_CLKSEL)) begin
            internal_osc_override <= hwdata[PCG_BIT_OSC_OVR];
         end
         if (is_reg(dp_addr, PCG_OFS_FAULT_CLR)) begin
            verify_fault_clear_bit <= hwdata[PCG_BIT_FAULT_CLR];
         end
         if (is_reg(dp_addr, PCG_OFS_LDO_RST_EN)) begin
            regulator_reset_enable <= hwdata[PCG_BIT_LDO_EN];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_mask <= PCG_IRQ_RST;
      end else if (wr_strobe && is_reg(dp_addr, PCG_OFS_INT_MASK)) begin
         int_mask <= hwdata[PCG_NUM_IRQ-1:0];
      end
   end

   // Power mode tracking
   always_comb begin
      next_mode = mode;
      case (mode)
         PCG_MODE_RUN: begin
            if (sleep_enter) begin
               next_mode = sleep_deep ? PCG_MODE_DEEP : PCG_MODE_SLEEP;
            end
         end
         PCG_MODE_SLEEP: begin
            if (wake_event) begin
               next_mode = PCG_MODE_RUN;
            end
         end
         PCG_MODE_DEEP: begin
            if (wake_event) begin
               next_mode = PCG_MODE_RUN;
            end
         end
         default: begin
            next_mode = PCG_MODE_RUN;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode <= PCG_MODE_RUN;
      end else begin
         mode <= next_mode;
      end
   end

   // Gating copy follows the mode the block is entering, so enables switch on the
   // same edge as the mode itself.
   always_comb begin
      next_clk_en = run_port_clock_gate;
      if (auto_clock_gating && next_mode == PCG_MODE_SLEEP) begin
         next_clk_en = sleep_port_clock_gate;
      end else if (auto_clock_gating && next_mode == PCG_MODE_DEEP) begin
         next_clk_en = deepsleep_port_clock_gate;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port_clk_en <= PCG_GATE_RST;
      end else begin
         port_clk_en <= next_clk_en;
      end
   end

   // Latch is open only while hclk is low, so an enable change can never cut a
   // high phase short.
   always_latch begin
      if (!hclk) begin
         en_latch <= port_clk_en;
      end
   end

   assign port_gclk = {NUM_PORTS{hclk}} & en_latch;

   // Access to an unclocked unit is answered with a fault pulse.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port_bus_fault <= 1'b0;
      end else begin
         port_bus_fault <= |(port_access & ~port_clk_en);
      end
   end

   // Deep-sleep oscillator override, sampled at entry
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         saved_src     <= PCG_SRC_MAIN;
         deep_override <= 1'b0;
      end else if (mode == PCG_MODE_RUN && next_mode == PCG_MODE_DEEP) begin
         saved_src     <= run_clk_src;
         deep_override <= internal_osc_override;
      end
   end

   // Fault substitution has priority over every other source choice.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sys_clk_src         <= PCG_SRC_MAIN;
         int_osc_power_up    <= 1'b0;
         main_osc_power_down <= 1'b0;
      end else if (clk_fault_active || clk_fault_detect) begin
         sys_clk_src         <= PCG_SRC_INTERNAL;
         int_osc_power_up    <= 1'b1;
         main_osc_power_down <= 1'b0;
      end else if (mode == PCG_MODE_RUN && next_mode == PCG_MODE_DEEP
                   && internal_osc_override) begin
         sys_clk_src         <= PCG_SRC_INTERNAL;
         int_osc_power_up    <= 1'b1;
         main_osc_power_down <= 1'b1;
      end else if (mode == PCG_MODE_DEEP && next_mode == PCG_MODE_RUN) begin
         sys_clk_src         <= saved_src;
         int_osc_power_up    <= saved_src == PCG_SRC_INTERNAL;
         main_osc_power_down <= 1'b0;
      end else if (mode != PCG_MODE_DEEP || !deep_override) begin
         // Main oscillator stays powered outside an overridden deep-sleep.
         sys_clk_src         <= (mode == PCG_MODE_DEEP) ? saved_src : run_clk_src;
         int_osc_power_up    <= ((mode == PCG_MODE_DEEP) ? saved_src : run_clk_src)
                                == PCG_SRC_INTERNAL;
         main_osc_power_down <= 1'b0;
      end
   end

   // Fault clears on the 1-to-0 write sequence; a new detection wins.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clr_prev         <= 1'b0;
         clk_fault_active <= 1'b0;
      end else begin
         clr_prev <= verify_fault_clear_bit;
         if (clk_fault_detect) begin
            clk_fault_active <= 1'b1;
         end else if (clr_prev && !verify_fault_clear_bit) begin
            clk_fault_active <= 1'b0;
         end
      end
   end

   // Regulator indication is asynchronous; two stages before use
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ldo_sync1 <= 1'b0;
         ldo_sync2 <= 1'b0;
         ldo_prev  <= 1'b0;
      end else begin
         ldo_sync1 <= ldo_unregulated;
         ldo_sync2 <= ldo_sync1;
         ldo_prev  <= ldo_sync2;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         part_reset_req <= 1'b0;
      end else begin
         part_reset_req <= ldo_sync2 && regulator_reset_enable;
      end
   end

   // Sticky interrupt status, cleared by a read; a same-cycle event survives
   always_comb begin
      irq_events                    = '0;
      irq_events[PCG_IRQ_CLK_FAULT] = clk_fault_detect;
      irq_events[PCG_IRQ_BUS_FAULT] = |(port_access & ~port_clk_en);
      irq_events[PCG_IRQ_LDO]       = ldo_sync2 && !ldo_prev;
      irq_events[PCG_IRQ_WAKE]      = (mode != PCG_MODE_RUN) && wake_event;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_status <= PCG_IRQ_RST;
      end else if (rd_strobe && is_reg(dp_addr, PCG_OFS_INT_STATUS)) begin
         int_status <= irq_events;
      end else begin
         int_status <= int_status | irq_events;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(int_status & int_mask);
      end
   end

   // Transfer size is not checked: only whole-word accesses are supported.
   logic unused_ok;
   assign unused_ok = &{1'b0, hsize, haddr[31:12], haddr[1:0], hwdata[31:NUM_PORTS]};

endmodule

// *** verif/pcg_cpu_model.sv ***
// Processor-side AHB-Lite master model: single word transfers.
// Assumes one slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
module pcg_cpu_model
   import pcg_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic      [31:0] haddr,
   output logic      [1:0]  htrans,
   output logic             hwrite,
   output logic      [2:0]  hsize,
   output logic      [31:0] hwdata
);
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end

   // Callers enter just after a rising edge; waits end only by the bench watchdog
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      hwrite <= 1'b1;
      htrans <= PCG_HTRANS_NONSEQ;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      // Released data must not look like the last value
      hwdata <= ~d;
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      hwrite <= 1'b0;
      htrans <= PCG_HTRANS_NONSEQ;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      do @(posedge hclk); while (hready !== 1'b1);
      d = hrdata;
   endtask
endmodule

// *** verif/pcg_top_props.sv ***
// Concurrent checks for the peripheral clock gating controller.
// Bound to pcg_top; sees only its ports, single hclk domain.
`timescale 1ns/1ps
module pcg_top_props
   import pcg_pkg::*;
#(
   parameter int NUM_PORTS = PCG_NUM_PORTS
) (
   input wire logic                 hclk,
   input wire logic                 hresetn,
   input wire logic                 hsel,
   input wire logic [1:0]           htrans,
   input wire logic                 hwrite,
   input wire logic                 hready,
   input wire logic                 hreadyout,
   input wire logic [NUM_PORTS-1:0] port_access,
   input wire logic [NUM_PORTS-1:0] port_clk_en,
   input wire logic                 port_bus_fault,
   input wire logic                 ldo_unregulated,
   input wire logic                 part_reset_req,
   input wire logic                 clk_fault_detect,
   input wire logic                 clk_fault_active,
   input wire logic [1:0]           sys_clk_src,
   input wire logic                 main_osc_power_down
);
   default clocking @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   property p_bus_fault;
      1'b1 |=> port_bus_fault == $past(|(port_access & ~port_clk_en));
   endproperty
   a_bus_fault: assert property (p_bus_fault)
      else $error("bus fault pulse does not match a gated access");
   property p_read_wait;
      hsel && hready && htrans == PCG_HTRANS_NONSEQ && !hwrite |=> !hreadyout ##1 hreadyout;
   endproperty
   a_read_wait: assert property (p_read_wait)
      else $error("read data phase is not one wait state");
   property p_write_ok;
      hsel && hready && htrans == PCG_HTRANS_NONSEQ && hwrite |=> hreadyout;
   endproperty
   a_write_ok: assert property (p_write_ok)
      else $error("write data phase stalled");
   property p_reset_en;
      $rose(hresetn) |-> port_clk_en == '0;
   endproperty
   a_reset_en: assert property (p_reset_en)
      else $error("unit clocks enabled out of reset");
   property p_fault_set;
      clk_fault_detect |=> clk_fault_active && sys_clk_src == PCG_SRC_INTERNAL;
   endproperty
   a_fault_set: assert property (p_fault_set)
      else $error("no safe clock after a verification fault");
   property p_ldo_rise;
      $rose(part_reset_req) |-> $past(ldo_unregulated, 3);
   endproperty
   a_ldo_rise: assert property (p_ldo_rise)
      else $error("part reset without regulator indication");
   property p_ldo_off;
      !ldo_unregulated [*4] |-> !part_reset_req;
   endproperty
   a_ldo_off: assert property (p_ldo_off)
      else $error("part reset held with regulator fine");
   property p_osc;
      main_osc_power_down |-> sys_clk_src == PCG_SRC_INTERNAL;
   endproperty
   a_osc: assert property (p_osc)
      else $error("main oscillator off while selected");
endmodule

// *** verif/peripheral_clock_gating_ctrl_tb_top.sv ***
// Self-checking bench for pcg_top: register access through the cpu model,
// power-mode events, port accesses, fault and regulator stimulus driven here.
`timescale 1ns/1ps
module peripheral_clock_gating_ctrl_tb_top;
   import pcg_pkg::*;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel, hwrite;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans, sys_clk_src;
   logic [2:0]  hsize;
   logic        hreadyout, hresp, port_bus_fault, int_osc_power_up;
   logic        main_osc_power_down, clk_fault_active, part_reset_req, irq;
   logic        auto_clock_gating = 1'b0;
   logic        sleep_enter = 1'b0;
   logic        sleep_deep = 1'b0;
   logic        wake_event = 1'b0;
   logic        clk_fault_detect = 1'b0;
   logic        ldo_unregulated = 1'b0;
   logic [1:0]  run_clk_src = 2'h2;
   logic [4:0]  port_access = 5'h00;
   logic [4:0]  port_clk_en, port_gclk;
   int          n_fail = 0;
   int          n_tests = 0;
   localparam logic [11:0] OFS [7] = '{PCG_OFS_RUN_GATE, PCG_OFS_SLEEP_GATE,
      PCG_OFS_DEEP_GATE, PCG_OFS_DEEP_CLKSEL, PCG_OFS_FAULT_CLR, PCG_OFS_LDO_RST_EN, 12'h1FC};

   always #12.5 hclk = ~hclk;

   pcg_cpu_model i_cpu (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   pcg_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .auto_clock_gating(auto_clock_gating), .sleep_enter(sleep_enter),
      .sleep_deep(sleep_deep), .wake_event(wake_event), .run_clk_src(run_clk_src),
      .clk_fault_detect(clk_fault_detect), .ldo_unregulated(ldo_unregulated),
      .port_access(port_access), .port_clk_en(port_clk_en), .port_gclk(port_gclk),
      .port_bus_fault(port_bus_fault), .sys_clk_src(sys_clk_src),
      .int_osc_power_up(int_osc_power_up), .main_osc_power_down(main_osc_power_down),
      .clk_fault_active(clk_fault_active), .part_reset_req(part_reset_req), .irq(irq));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] d;
      i_cpu.rd(a, d);
      chk(d, exp);
   endtask

   // Event codes: 0 sleep entry, 1 wake, 2 clock fault detect
   task automatic evt(input int k);
      sleep_enter <= (k == 0);
      wake_event <= (k == 1);
      clk_fault_detect <= (k == 2);
      @(posedge hclk);
      sleep_enter <= 1'b0;
      wake_event <= 1'b0;
      clk_fault_detect <= 1'b0;
      @(posedge hclk);
   endtask

   task automatic acc(input int i, input logic exp);
      port_access <= 5'(5'h01 << i);
      @(posedge hclk);
      port_access <= 5'h00;
      @(posedge hclk);
      chk(port_bus_fault, exp);
   endtask

   task automatic end_of_test;
      if (n_fail == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk(port_clk_en, 5'h00);
      foreach (OFS[k]) rchk(OFS[k], 32'h0);
      i_cpu.wr(PCG_OFS_RUN_GATE, 32'h0000_0015);
      rchk(PCG_OFS_RUN_GATE, 32'h0000_0015);
      chk(port_clk_en, 5'h15);
      #5 chk(port_gclk, 5'h15);
      @(posedge hclk);
      for (int i = 0; i < 5; i++) acc(i, i % 2 == 1);
      i_cpu.wr(PCG_OFS_SLEEP_GATE, 32'h0000_000A);
      i_cpu.wr(PCG_OFS_DEEP_GATE, 32'h0000_0004);
      evt(0);
      chk(port_clk_en, 5'h15);
      evt(1);
      auto_clock_gating <= 1'b1;
      evt(0);
      chk(port_clk_en, 5'h0A);
      acc(0, 1'b1);
      evt(1);
      chk(port_clk_en, 5'h15);
      sleep_deep <= 1'b1;
      evt(0);
      chk(port_clk_en, 5'h04);
      chk({sys_clk_src, main_osc_power_down}, 3'b100);
      evt(1);
      i_cpu.wr(PCG_OFS_DEEP_CLKSEL, 32'h0000_0001);
      rchk(PCG_OFS_DEEP_CLKSEL, 32'h0000_0001);
      evt(0);
      chk({sys_clk_src, int_osc_power_up, main_osc_power_down}, {PCG_SRC_INTERNAL, 2'b11});
      rchk(PCG_OFS_STATE, 32'h0000_0414);
      run_clk_src <= 2'h3;
      evt(1);
      chk({sys_clk_src, int_osc_power_up, main_osc_power_down}, 4'b1000);
      run_clk_src <= 2'h2;
      sleep_deep <= 1'b0;
      evt(2);
      chk({sys_clk_src, clk_fault_active}, {PCG_SRC_INTERNAL, 1'b1});
      i_cpu.wr(PCG_OFS_FAULT_CLR, 32'h0000_0001);
      repeat (2) @(posedge hclk);
      chk(clk_fault_active, 1'b1);
      rchk(PCG_OFS_FAULT_CLR, 32'h0000_0001);
      i_cpu.wr(PCG_OFS_FAULT_CLR, 32'h0000_0000);
      repeat (2) @(posedge hclk);
      chk(clk_fault_active, 1'b0);
      ldo_unregulated <= 1'b1;
      repeat (5) @(posedge hclk);
      chk(part_reset_req, 1'b0);
      i_cpu.wr(PCG_OFS_LDO_RST_EN, 32'h0000_0001);
      repeat (2) @(posedge hclk);
      chk(part_reset_req, 1'b1);
      ldo_unregulated <= 1'b0;
      repeat (4) @(posedge hclk);
      chk(part_reset_req, 1'b0);
      // Every event kind has fired by now while fully masked
      chk(irq, 1'b0);
      rchk(PCG_OFS_INT_STATUS, 32'h0000_000F);
      rchk(PCG_OFS_INT_STATUS, 32'h0000_0000);
      i_cpu.wr(PCG_OFS_INT_MASK, 32'h0000_0002);
      acc(1, 1'b1);
      repeat (3) @(posedge hclk);
      chk(irq, 1'b1);
      rchk(PCG_OFS_INT_STATUS, 32'h0000_0002);
      repeat (3) @(posedge hclk);
      chk(irq, 1'b0);
      // Mid-run reset must bring the gating and single-bit control registers back to their reset value
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk(port_clk_en, 5'h00);
      foreach (OFS[k]) rchk(OFS[k], 32'h0);
      end_of_test();
   end

   // Whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge hclk);
      n_fail++;
      end_of_test();
   end
endmodule

bind pcg_top pcg_top_props #(.NUM_PORTS(NUM_PORTS)) i_props (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .port_access(port_access), .port_clk_en(port_clk_en), .port_bus_fault(port_bus_fault),
   .ldo_unregulated(ldo_unregulated), .part_reset_req(part_reset_req),
   .clk_fault_detect(clk_fault_detect), .clk_fault_active(clk_fault_active),
   .sys_clk_src(sys_clk_src), .main_osc_power_down(main_osc_power_down));
